// ### hdl/bcgu_defs.vh
// Constants for the branch clock gating unit
`ifndef BCGU_DEFS_VH
`define BCGU_DEFS_VH
`define BCGU_NUM_BRANCH 53
`define BCGU_NUM_BASE 12
`define BCGU_ADDR_W 6
`define BCGU_DATA_W 32
// Base clock indices
`define BCGU_BASE_SAFE 4'h0
`define BCGU_BASE_SYS 4'h1
`define BCGU_BASE_PCR 4'h2
`define BCGU_BASE_VEH 4'h3
`define BCGU_BASE_MIX 4'h4
`define BCGU_BASE_OUT 4'h5
`define BCGU_BASE_UART 4'h6
`define BCGU_BASE_SPI 4'h7
`define BCGU_BASE_CNT 4'h8
`define BCGU_BASE_ADC 4'h9
`define BCGU_BASE_USBI2C 4'hA
`define BCGU_BASE_USB 4'hB
// Last branch index bound to each base clock except USB, which takes the rest
`define BCGU_LAST_SAFE 0
`define BCGU_LAST_SYS 18
`define BCGU_LAST_PCR 19
`define BCGU_LAST_VEH 26
`define BCGU_LAST_MIX 37
`define BCGU_LAST_OUT 38
`define BCGU_LAST_UART 40
`define BCGU_LAST_SPI 43
`define BCGU_LAST_CNT 47
`define BCGU_LAST_ADC 50
`define BCGU_LAST_USBI2C 51
// Config register bit positions
`define BCGU_BIT_RUN 0
`define BCGU_BIT_AUTO 1
`define BCGU_BIT_WAKE 2
`define BCGU_BIT_ON 3
`define BCGU_BIT_PD 0
// Extra register addresses
`define BCGU_ADDR_PD 6'h3E
`define BCGU_ADDR_STAT 6'h3F
// Tie-off masks: FIX bit set means the mode bit ignores writes, TIE bit set forces it to 1
`define BCGU_RUN_FIX 53'h0000000008000F
`define BCGU_RUN_TIE 53'h0000000008000F
`define BCGU_AUTO_FIX 53'h00000000000001
`define BCGU_AUTO_TIE 53'h00000000000000
`define BCGU_WAKE_FIX 53'h00000000000001
`define BCGU_WAKE_TIE 53'h00000000000000
// Reset values of writable bits
`define BCGU_RUN_RST 53'h1FFFFFFFFFFFFF
`define BCGU_AUTO_RST 53'h00000000000000
`define BCGU_WAKE_RST 53'h00000000000000
`endif

// ### hdl/bcgu_branch_clock_gating_unit.v
// Branch clock gating unit: per-branch gating of base clocks with register control
`include "bcgu_defs.vh"
module bcgu_branch_clock_gating_unit (
  input wire ref_clk_in,
  input wire reset_n_in,
  input wire [`BCGU_ADDR_W-1:0] addr_in,
  input wire [`BCGU_DATA_W-1:0] wr_data_in,
  input wire wr_en_in,
  input wire rd_en_in,
  output reg [`BCGU_DATA_W-1:0] rd_data_out,
  input wire [`BCGU_NUM_BASE-1:0] base_clk_in,
  input wire wakeup_in,
  input wire [`BCGU_NUM_BRANCH-1:0] mdis_ack_in,
  output wire [`BCGU_NUM_BRANCH-1:0] mdis_req_out,
  output wire [`BCGU_NUM_BRANCH-1:0] branch_clk_out,
  output wire [`BCGU_NUM_BASE-1:0] base_off_out
);

  localparam NB = `BCGU_NUM_BRANCH;
  localparam NK = `BCGU_NUM_BASE;

  reg [NB-1:0] run_q;
  reg [NB-1:0] auto_q;
  reg [NB-1:0] wake_q;
  reg pd_q;
  reg [NB-1:0] en_q;
  reg [NB-1:0] en_d;
  reg [NB-1:0] req_q;
  reg [NB-1:0] req_d;
  reg [NB-1:0] gate_q;
  reg [NB-1:0] gate_d;
  reg [NK-1:0] base_off_q;
  reg [NK-1:0] base_off_d;
  reg [NB-1:0] base_low;
  reg [NB-1:0] run_next;
  reg [NB-1:0] want_on;
  integer i;
  integer k;

  // Fixed source of each branch
  function [3:0] base_of;
    input integer b;
    begin
      if (b <= `BCGU_LAST_SAFE) base_of = `BCGU_BASE_SAFE;
      else if (b <= `BCGU_LAST_SYS) base_of = `BCGU_BASE_SYS;
      else if (b <= `BCGU_LAST_PCR) base_of = `BCGU_BASE_PCR;
      else if (b <= `BCGU_LAST_VEH) base_of = `BCGU_BASE_VEH;
      else if (b <= `BCGU_LAST_MIX) base_of = `BCGU_BASE_MIX;
      else if (b <= `BCGU_LAST_OUT) base_of = `BCGU_BASE_OUT;
      else if (b <= `BCGU_LAST_UART) base_of = `BCGU_BASE_UART;
      else if (b <= `BCGU_LAST_SPI) base_of = `BCGU_BASE_SPI;
      else if (b <= `BCGU_LAST_CNT) base_of = `BCGU_BASE_CNT;
      else if (b <= `BCGU_LAST_ADC) base_of = `BCGU_BASE_ADC;
      else if (b <= `BCGU_LAST_USBI2C) base_of = `BCGU_BASE_USBI2C;
      else base_of = `BCGU_BASE_USB;
    end
  endfunction

  // Effective mode bits with tie-offs applied
  wire [NB-1:0] run_eff = (run_q & ~`BCGU_RUN_FIX) | `BCGU_RUN_TIE;
  wire [NB-1:0] auto_eff = (auto_q & ~`BCGU_AUTO_FIX) | `BCGU_AUTO_TIE;
  wire [NB-1:0] wake_eff = (wake_q & ~`BCGU_WAKE_FIX) | `BCGU_WAKE_TIE;
  wire sel_branch = (addr_in < NB);

  // Mode registers and wake-up
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_q <= `BCGU_RUN_RST;
      auto_q <= `BCGU_AUTO_RST;
      wake_q <= `BCGU_WAKE_RST;
      pd_q <= 1'b0;
    end else begin
      run_q <= run_next;
      if (wr_en_in && sel_branch) begin
        auto_q[addr_in] <= wr_data_in[`BCGU_BIT_AUTO];
        wake_q[addr_in] <= wr_data_in[`BCGU_BIT_WAKE];
      end
      if (wr_en_in && addr_in == `BCGU_ADDR_PD) begin
        pd_q <= wr_data_in[`BCGU_BIT_PD];
      end
    end
  end

  // Run bit: software write, then wake-up sets enabled sleepers unless pd_q is set
  always @* begin
    run_next = run_q;
    if (wr_en_in && sel_branch) begin
      run_next[addr_in] = wr_data_in[`BCGU_BIT_RUN];
    end
    if (wakeup_in && !pd_q) begin
      run_next = run_next | wake_eff;
    end
  end

  // Request and enable per branch
  always @* begin
    want_on = run_eff & ~({NB{pd_q}} & wake_eff);
    en_d = en_q;
    req_d = req_q;
    for (i = 0; i < NB; i = i + 1) begin
      if (want_on[i]) begin
        en_d[i] = 1'b1;
        req_d[i] = 1'b0;
      end else if (auto_eff[i] && en_q[i]) begin
        req_d[i] = 1'b1;
        en_d[i] = ~mdis_ack_in[i];
      end else begin
        en_d[i] = 1'b0;
        req_d[i] = 1'b0;
      end
    end
  end

  // Gate follows enable only while its base is low
  always @* begin
    for (i = 0; i < NB; i = i + 1) begin
      base_low[i] = ~base_clk_in[base_of(i)];
      gate_d[i] = base_low[i] ? en_q[i] : gate_q[i];
    end
  end

  // Base idle status
  always @* begin
    base_off_d = {NK{1'b1}};
    for (k = 0; k < NK; k = k + 1) begin
      for (i = 0; i < NB; i = i + 1) begin
        if (base_of(i) == k[3:0] && gate_q[i]) begin
          base_off_d[k] = 1'b0;
        end
      end
    end
  end

  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      en_q <= `BCGU_RUN_RST;
      req_q <= {NB{1'b0}};
      gate_q <= `BCGU_RUN_RST;
      base_off_q <= {NK{1'b0}};
    end else begin
      en_q <= en_d;
      req_q <= req_d;
      gate_q <= gate_d;
      base_off_q <= base_off_d;
    end
  end

  // Register read, data in the following cycle
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_data_out <= {`BCGU_DATA_W{1'b0}};
    end else if (rd_en_in) begin
      rd_data_out <= {`BCGU_DATA_W{1'b0}};
      if (sel_branch) begin
        rd_data_out[`BCGU_BIT_RUN] <= run_eff[addr_in];
        rd_data_out[`BCGU_BIT_AUTO] <= auto_eff[addr_in];
        rd_data_out[`BCGU_BIT_WAKE] <= wake_eff[addr_in];
        rd_data_out[`BCGU_BIT_ON] <= gate_q[addr_in];
      end else if (addr_in == `BCGU_ADDR_PD) begin
        rd_data_out[`BCGU_BIT_PD] <= pd_q;
      end else if (addr_in == `BCGU_ADDR_STAT) begin
        rd_data_out[NK-1:0] <= base_off_q;
      end
    end
  end

  // Branch clocks share their base edges
  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1) begin : gen_gate
      assign branch_clk_out[g] = base_clk_in[base_of(g)] & gate_q[g];
    end
  endgenerate

  assign mdis_req_out = req_q;
  assign base_off_out = base_off_q;

endmodule

// ### test/bcgu_far_model.sv
// Far side model: base clock sources and bus master acknowledges
module bcgu_far_model (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [52:0] req_in,
  output logic [11:0] base_out,
  output logic [52:0] ack_out
);
  timeunit 1ns / 1ps;
  logic [1:0] cnt_q;
  logic [52:0] req_q;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) {cnt_q, req_q, ack_out} <= '0;
    else begin
      {cnt_q, req_q} <= {cnt_q + 2'h1, req_in};
      ack_out <= req_in & (req_q | 53'h15555555555555);
    end
  end
  assign base_out = {{6{cnt_q[1]}}, {6{cnt_q[0]}}};
endmodule

// ### test/bcgu_asserts.sv
// Assertions on the gating unit ports
module bcgu_asserts (
  input wire logic ref_clk_in, reset_n_in, wr_en_in, rd_en_in, wakeup_in,
  input wire logic [5:0] addr_in,
  input wire logic [31:0] wr_data_in, rd_data_out,
  input wire logic [11:0] base_clk_in, base_off_out,
  input wire logic [52:0] mdis_ack_in, mdis_req_out, branch_clk_out
);
  timeunit 1ns / 1ps;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  rd_hold_a: assert property (!$past(rd_en_in) |-> $stable(rd_data_out))
    else $error("read moved");
  safe_on_a: assert property (branch_clk_out[0] == base_clk_in[0])
    else $error("safe gated");
  glitch_free_a: assert property ($changed(branch_clk_out[52]) |->
    $changed(base_clk_in[11])) else $error("glitch");
  status_and_a: assert property ($past(base_clk_in[11]) |->
    base_off_out[11] == !$past(branch_clk_out[52])) else $error("status");
  base_map_a: assert property (branch_clk_out[27] |-> base_clk_in[4])
    else $error("base map");
  safe_read_a: assert property (rd_en_in && addr_in == 6'h00 |=> rd_data_out == 32'h9)
    else $error("safe bits");
  unmapped_a: assert property (rd_en_in && addr_in == 6'h38 |=> rd_data_out == 32'h0)
    else $error("unmapped");
  run_tie_a: assert property (rd_en_in && addr_in inside {[6'h01:6'h03]} |=> rd_data_out[0])
    else $error("run tie");
  cover property ($rose(mdis_req_out[38]));
  cover property ($rose(base_off_out[11]));
  cover property (wakeup_in && base_off_out[11]);
endmodule
bind bcgu_branch_clock_gating_unit bcgu_asserts chk (.*);

// ### test/testbench.sv
// Bench for the branch clock gating unit
module testbench;
  timeunit 1ns / 1ps;
  logic ref_clk_in = '0, reset_n_in = '0, wr_en_in = '0, rd_en_in = '0, wakeup_in = '0;
  logic [5:0] addr_in = '0, ra [4] = '{6'h00, 6'h01, 6'h05, 6'h38};
  logic [31:0] wr_data_in = '0, rd_data_out;
  logic [11:0] base_clk_in, base_off_out;
  logic [52:0] mdis_ack_in, mdis_req_out, branch_clk_out;
  int n_errors = 0, n_checks = 0;
  always #2 ref_clk_in = ~ref_clk_in;
  bcgu_far_model far (.clk_in(ref_clk_in), .reset_n_in, .req_in(mdis_req_out),
    .base_out(base_clk_in), .ack_out(mdis_ack_in));
  bcgu_branch_clock_gating_unit uut (.*);
  task chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task op(input logic w, r, k, input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    {wr_en_in, rd_en_in, wakeup_in, addr_in, wr_data_in} <= {w, r, k, a, d};
    @(posedge ref_clk_in);
    {wr_en_in, rd_en_in, wakeup_in} <= 3'h0;
    #1;
  endtask
  task wst(input int i, input logic v);
    for (int n = 0; n < 40 && base_off_out[i] !== v; n++) @(posedge ref_clk_in);
    #1 chk(base_off_out[i], v);
  endtask
  task end_sim;
    $display("%0d checks, %0d errors", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #4000 n_errors++;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge ref_clk_in);
    reset_n_in <= 1'h1;
    op(1, 0, 0, 6'h00, 32'hF);
    op(1, 0, 0, 6'h01, 32'h0);
    foreach (ra[i]) begin
      op(0, 1, 0, ra[i], 32'h0);
      chk(rd_data_out, ra[i] == 6'h38 ? 32'h0 : 32'h9);
    end
    $display("Test registers done");
    op(1, 0, 0, 6'h34, 32'h0);
    wst(11, 1'h1);
    op(1, 0, 0, 6'h26, 32'h2);
    #4 chk(mdis_req_out[38], 1'h1);
    wst(5, 1'h1);
    op(1, 0, 0, 6'h34, 32'h4);
    op(0, 0, 1, 6'h00, 32'h0);
    wst(11, 1'h0);
    op(1, 0, 0, 6'h3E, 32'h1);
    wst(11, 1'h1);
    op(1, 0, 0, 6'h34, 32'h4);
    op(0, 0, 1, 6'h00, 32'h0);
    repeat (8) @(posedge ref_clk_in);
    #1 chk(base_off_out[11], 1'h1);
    op(0, 1, 0, 6'h34, 32'h0);
    chk(rd_data_out, 32'h4);
    op(1, 0, 0, 6'h3E, 32'h0);
    repeat (8) @(posedge ref_clk_in);
    #1 chk(base_off_out[11], 1'h1);
    op(0, 0, 1, 6'h00, 32'h0);
    wst(11, 1'h0);
    $display("Test gating done");
    end_sim;
  end
endmodule
